//--- pkg/clk_sup_pkg.sv
// Purpose: Shared constants and types for the clock supervisor.
// Assumes: AXI4-Lite register map with 32-bit data and one word per register.
// Notes:   Oscillator input levels are sampled on aclk.
package clk_sup_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] CFG_OFS    = 8'h00;
	localparam logic [7:0] CTRL_OFS   = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] IRQ_OFS    = 8'h0C;
	localparam logic [7:0] CMD_OFS    = 8'h10;

	// ==========================================================
	// Field positions
	localparam int CMD_SLEEP_BIT = 0;
	localparam int CMD_WAKE_BIT  = 1;
	localparam int IRQ_FLAG_BIT  = 0;
	localparam int IRQ_EN_BIT    = 1;

	// ==========================================================
	// Oscillator configuration and clock select encodings
	localparam logic [2:0] OSC_LP    = 3'h0;
	localparam logic [2:0] OSC_XT    = 3'h1;
	localparam logic [2:0] OSC_HS    = 3'h2;
	localparam logic [2:0] OSC_RC    = 3'h3;
	localparam logic [2:0] OSC_INT   = 3'h4;
	localparam logic [1:0] SCS_CFG   = 2'h0;
	localparam logic [1:0] SCS_TMR   = 2'h1;

	localparam logic [1:0] SEL_INT   = 2'h0;
	localparam logic [1:0] SEL_LOW   = 2'h1;
	localparam logic [1:0] SEL_EXT   = 2'h2;

	// ==========================================================
	// Counts, reset values and bus response codes
	localparam int         OST_EDGES_DEF  = 1024;
	localparam int         SAMPLE_DIV_DEF = 64;
	localparam int         POWER_UP_TIMER_EDGES_DEF = 16;
	localparam logic [3:0] FREQ_SEL_RST   = 4'h7;
	localparam logic [1:0] AXI_OKAY       = 2'h0;
	localparam logic [1:0] AXI_SLVERR     = 2'h2;

	typedef struct packed {
		logic       power_up_timer_en;
		logic       monitor_enable_cfg;
		logic       switchover_enable_cfg;
		logic [2:0] oscillator_config_field;
	} cfg_s;

	typedef struct packed {
		logic [3:0] internal_freq_select;
		logic [1:0] clock_select_field;
	} ctrl_s;

	localparam cfg_s  CFG_RST  = '{1'b0, 1'b1, 1'b1, OSC_HS};
	localparam ctrl_s CTRL_RST = '{FREQ_SEL_RST, SCS_CFG};

	typedef enum logic [2:0] {
		ST_POWER_UP_TIMER, ST_SLEEP, ST_INT, ST_COUNT, ST_WAIT_IFALL, ST_HOLD, ST_EXT, ST_FAIL
	} seq_state_e;

endpackage

//--- logic/clk_supervisor.sv
// Purpose: Two-speed start-up sequencer and fail-safe clock monitor.
// Assumes: ext, int and low-freq oscillator levels are synchronous to aclk.
// Notes:   Register map and oscillator encodings are local choices of this block.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module clk_supervisor #(
	parameter int ADDR_W     = 8,
	parameter int OST_EDGES  = clk_sup_pkg::OST_EDGES_DEF,
	parameter int SAMPLE_DIV = clk_sup_pkg::SAMPLE_DIV_DEF,
	parameter int POWER_UP_TIMER_EDGES = clk_sup_pkg::POWER_UP_TIMER_EDGES_DEF
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Oscillator levels
	input  wire logic              ext_osc_in,
	input  wire logic              int_osc_in,
	input  wire logic              lf_osc_in,
	input  wire logic              pll_ready_bit,
	// Clock mux control and status
	output logic [1:0]             clk_mux_sel,
	output logic [3:0]             internal_freq_select,
	output logic                   startup_done_bit,
	output logic                   osc_fail_irq
);
	import clk_sup_pkg::*;

	localparam int OST_W  = $clog2(OST_EDGES);
	localparam int HALF   = SAMPLE_DIV / 2;
	localparam int DIV_W  = $clog2(HALF);
	localparam int POWER_UP_TIMER_W = $clog2(POWER_UP_TIMER_EDGES + 1);

	cfg_s              cfg_r, run_cfg_r;
	ctrl_s             ctrl_r;
	seq_state_e        state_r;
	logic [OST_W-1:0]  ost_cnt_r;
	logic [POWER_UP_TIMER_W-1:0] power_up_timer_cnt_r;
	logic [DIV_W-1:0]  div_cnt_r;
	logic              ext_d_r, int_d_r, lf_d_r;
	logic              samp_r, latch_r, fail_raw_r, fail_s1_r, fail_s2_r;
	logic              fail_cond_r, osc_fail_flag_r, osc_fail_irq_enable_r;
	logic [1:0]        clk_sel_r;
	logic              startup_done_r, irq_r;

	// ==========================================================
	// Register bus slave
	logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]        bresp_r, rresp_r;
	logic [31:0]       rdata_r, wdata_r;
	logic [3:0]        wstrb_r;
	logic [7:0]        waddr_r;
	logic              wr_en;

	// Both halves captured and no response pending: perform the write
	assign wr_en = !awready_r && !wready_r && !bvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= AXI_OKAY;
			waddr_r   <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			if (awvalid && awready_r) begin
				awready_r <= 1'b0;
				waddr_r   <= awaddr[7:0];
			end
			if (wvalid && wready_r) begin
				wready_r <= 1'b0;
				wdata_r  <= wdata;
				wstrb_r  <= wstrb;
			end
			if (wr_en) begin
				bvalid_r <= 1'b1;
				if (waddr_r == CFG_OFS || waddr_r == CTRL_OFS || waddr_r == IRQ_OFS
						|| waddr_r == CMD_OFS) begin
					bresp_r <= AXI_OKAY;
				end else begin
					bresp_r <= AXI_SLVERR;
				end
			end else if (bvalid_r && bready) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	logic wr_lane0, cfg_wr, ctrl_wr, irq_wr, sleep_req, wake_req, scs_chg;
	assign wr_lane0  = wr_en && wstrb_r[0];
	assign cfg_wr    = wr_lane0 && waddr_r == CFG_OFS;
	assign ctrl_wr   = wr_lane0 && waddr_r == CTRL_OFS;
	assign irq_wr    = wr_lane0 && waddr_r == IRQ_OFS;
	assign sleep_req = wr_lane0 && waddr_r == CMD_OFS && wdata_r[CMD_SLEEP_BIT];
	assign wake_req  = wr_lane0 && waddr_r == CMD_OFS && wdata_r[CMD_WAKE_BIT]
		&& !wdata_r[CMD_SLEEP_BIT];
	assign scs_chg   = ctrl_wr && wdata_r[1:0] != ctrl_r.clock_select_field;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r                  <= CFG_RST;
			ctrl_r                 <= CTRL_RST;
			osc_fail_irq_enable_r  <= 1'b0;
		end else begin
			if (cfg_wr) begin
				cfg_r <= cfg_s'(wdata_r[5:0]);
			end
			if (ctrl_wr) begin
				ctrl_r <= ctrl_s'(wdata_r[5:0]);
			end
			if (irq_wr) begin
				osc_fail_irq_enable_r <= wdata_r[IRQ_EN_BIT];
			end
		end
	end

	logic [31:0] rd_nxt;
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (araddr[7:0] == CFG_OFS) begin
			rd_nxt[5:0] = cfg_r;
		end else if (araddr[7:0] == CTRL_OFS) begin
			rd_nxt[5:0] = ctrl_r;
		end else if (araddr[7:0] == STATUS_OFS) begin
			rd_nxt = {24'h000000, state_r, fail_cond_r, pll_ready_bit, clk_sel_r,
				startup_done_r};
		end else if (araddr[7:0] == IRQ_OFS) begin
			rd_nxt[IRQ_FLAG_BIT] = osc_fail_flag_r;
			rd_nxt[IRQ_EN_BIT]   = osc_fail_irq_enable_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= AXI_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_nxt;
			if (araddr[7:0] == CFG_OFS || araddr[7:0] == CTRL_OFS
					|| araddr[7:0] == STATUS_OFS || araddr[7:0] == IRQ_OFS
					|| araddr[7:0] == CMD_OFS) begin
				rresp_r <= AXI_OKAY;
			end else begin
				rresp_r <= AXI_SLVERR;
			end
		end else if (rvalid_r && rready) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// ==========================================================
	// Oscillator edge detection
	logic ext_fall, int_fall, lf_rise;
	assign ext_fall = ext_d_r && !ext_osc_in;
	assign int_fall = int_d_r && !int_osc_in;
	assign lf_rise  = !lf_d_r && lf_osc_in;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_d_r <= 1'b0;
			int_d_r <= 1'b0;
			lf_d_r  <= 1'b0;
		end else begin
			ext_d_r <= ext_osc_in;
			int_d_r <= int_osc_in;
			lf_d_r  <= lf_osc_in;
		end
	end

	// ==========================================================
	// Start decision from the live settings
	logic crystal, ext_direct, two_speed, needs_ost, ost_done, fail_det;
	logic [1:0] sel_eff;
	// A select write is decoded from its data, since ctrl_r lands a cycle later
	assign sel_eff    = scs_chg ? wdata_r[1:0] : ctrl_r.clock_select_field;
	assign crystal    = cfg_r.oscillator_config_field == OSC_LP
		|| cfg_r.oscillator_config_field == OSC_XT
		|| cfg_r.oscillator_config_field == OSC_HS;
	assign ext_direct = sel_eff == SCS_CFG && !crystal
		&& cfg_r.oscillator_config_field != OSC_INT;
	assign two_speed  = (cfg_r.switchover_enable_cfg || cfg_r.monitor_enable_cfg)
		&& sel_eff == SCS_CFG && crystal;
	assign needs_ost  = (sel_eff == SCS_CFG && crystal)
		|| sel_eff == SCS_TMR;
	assign ost_done   = ext_fall && ost_cnt_r == OST_W'(OST_EDGES - 1);
	assign fail_det   = fail_s2_r && state_r == ST_EXT;

	// ==========================================================
	// Start-up sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r        <= ST_POWER_UP_TIMER;
			run_cfg_r      <= CFG_RST;
			clk_sel_r      <= SEL_LOW;
			startup_done_r <= 1'b0;
			ost_cnt_r      <= '0;
			power_up_timer_cnt_r     <= '0;
			fail_cond_r    <= 1'b0;
		end else if (sleep_req) begin
			state_r        <= ST_SLEEP;
			clk_sel_r      <= SEL_LOW;
			startup_done_r <= 1'b0;
			ost_cnt_r      <= '0;
			fail_cond_r    <= 1'b0;
		end else if ((state_r == ST_POWER_UP_TIMER && (!cfg_r.power_up_timer_en
				|| power_up_timer_cnt_r == POWER_UP_TIMER_W'(POWER_UP_TIMER_EDGES)))
				|| (state_r == ST_SLEEP && wake_req)
				|| (scs_chg && state_r != ST_POWER_UP_TIMER && state_r != ST_SLEEP)) begin
			// Snapshot taken here; the monitor keys off it, not the live config
			run_cfg_r      <= cfg_r;
			ost_cnt_r      <= '0;
			startup_done_r <= 1'b0;
			if (needs_ost) begin
				// A select change keeps running internally while the timer restarts
				state_r   <= ST_COUNT;
				clk_sel_r <= (two_speed || scs_chg || sel_eff == SCS_TMR)
					? SEL_INT : SEL_LOW;
			end else if (ext_direct) begin
				state_r        <= ST_EXT;
				clk_sel_r      <= SEL_EXT;
				startup_done_r <= 1'b1;
				fail_cond_r    <= 1'b0;
			end else begin
				state_r   <= ST_INT;
				clk_sel_r <= SEL_INT;
			end
		end else begin
			case (state_r)
				ST_POWER_UP_TIMER: begin
					if (lf_rise) begin
						power_up_timer_cnt_r <= power_up_timer_cnt_r + POWER_UP_TIMER_W'(1);
					end
				end
				ST_COUNT: begin
					if (ost_done) begin
						state_r <= ST_WAIT_IFALL;
					end else if (ext_fall) begin
						ost_cnt_r <= ost_cnt_r + OST_W'(1);
					end
				end
				ST_WAIT_IFALL: begin
					if (int_fall) begin
						state_r        <= ST_HOLD;
						clk_sel_r      <= SEL_LOW;
						startup_done_r <= ctrl_r.clock_select_field == SCS_CFG;
					end
				end
				ST_HOLD: begin
					if (ext_fall) begin
						state_r     <= ST_EXT;
						clk_sel_r   <= SEL_EXT;
						fail_cond_r <= 1'b0;
					end
				end
				ST_EXT: begin
					if (fail_det) begin
						state_r        <= ST_FAIL;
						clk_sel_r      <= SEL_INT;
						startup_done_r <= 1'b0;
						fail_cond_r    <= 1'b1;
					end
				end
				default: begin
					// ST_INT, ST_SLEEP, ST_FAIL hold until firmware acts
				end
			endcase
		end
	end

	// ==========================================================
	// Fail-safe monitor: sample clock is the low-freq source divided down
	logic mon_active, samp_toggle;
	assign mon_active  = run_cfg_r.monitor_enable_cfg && state_r == ST_EXT;
	assign samp_toggle = lf_rise && div_cnt_r == DIV_W'(HALF - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_r <= '0;
			samp_r    <= 1'b0;
		end else if (lf_rise) begin
			div_cnt_r <= samp_toggle ? '0 : div_cnt_r + DIV_W'(1);
			samp_r    <= samp_r ^ samp_toggle;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_r    <= 1'b1;
			fail_raw_r <= 1'b0;
		end else if (!mon_active) begin
			latch_r    <= 1'b1;
			fail_raw_r <= 1'b0;
		end else begin
			// Set wins so a falling edge on the sample edge is not missed
			if (ext_fall) begin
				latch_r <= 1'b1;
			end else if (samp_toggle && !samp_r) begin
				latch_r <= 1'b0;
			end
			if (samp_toggle && samp_r && !latch_r && !ext_fall) begin
				fail_raw_r <= 1'b1;
			end
		end
	end

	// Detector is treated as another domain, so it is synchronised
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_s1_r <= 1'b0;
			fail_s2_r <= 1'b0;
		end else begin
			fail_s1_r <= fail_raw_r;
			fail_s2_r <= fail_s1_r;
		end
	end

	// ==========================================================
	// Fail flag and interrupt request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_fail_flag_r <= 1'b0;
			irq_r           <= 1'b0;
		end else begin
			if (fail_det) begin
				osc_fail_flag_r <= 1'b1;
			end else if (irq_wr && wdata_r[IRQ_FLAG_BIT]) begin
				osc_fail_flag_r <= 1'b0;
			end
			irq_r <= osc_fail_flag_r && osc_fail_irq_enable_r;
		end
	end

	assign awready              = awready_r;
	assign wready               = wready_r;
	assign bvalid               = bvalid_r;
	assign bresp                = bresp_r;
	assign arready              = arready_r;
	assign rvalid               = rvalid_r;
	assign rdata                = rdata_r;
	assign rresp                = rresp_r;
	assign clk_mux_sel          = clk_sel_r;
	assign internal_freq_select = ctrl_r.internal_freq_select;
	assign startup_done_bit     = startup_done_r;
	assign osc_fail_irq         = irq_r;

	// ==========================================================
	// Checks
	a_ost_full_count: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(state_r == ST_WAIT_IFALL) |-> $past(ost_cnt_r) == OST_W'(OST_EDGES - 1))
		else $error("start-up count left early");
	a_two_speed_only: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(state_r == ST_COUNT) && !$past(scs_chg) && ctrl_r.clock_select_field == SCS_CFG
		&& clk_sel_r == SEL_INT |-> run_cfg_r.oscillator_config_field <= OSC_HS)
		else $error("two-speed ran for a non-crystal mode");
	a_done_at_ifall: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_WAIT_IFALL && int_fall && !sleep_req && !scs_chg
		|=> clk_sel_r == SEL_LOW ##1 (clk_sel_r != SEL_INT || $past(scs_chg)))
		else $error("clock not held low after internal fall");
	a_hold_to_ext: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_HOLD && ext_fall && !sleep_req && !scs_chg
		|=> clk_sel_r == SEL_EXT && state_r == ST_EXT)
		else $error("no switch to external clock");
	a_sleep_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		sleep_req |=> state_r == ST_SLEEP && !startup_done_r && !fail_cond_r)
		else $error("sleep did not abort start-up");
	a_done_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
		startup_done_r |-> clk_sel_r != SEL_INT)
		else $error("done bit set while on internal clock");
	a_fail_switch: assert property (@(posedge aclk) disable iff (!aresetn)
		fail_det && !sleep_req && !scs_chg |=> clk_sel_r == SEL_INT && osc_fail_flag_r
		##2 irq_r == osc_fail_irq_enable_r)
		else $error("failure not handled");
	a_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
		fail_det && irq_wr |=> osc_fail_flag_r)
		else $error("fail flag clear beat a new failure");
	a_sync_two_stage: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(fail_s2_r) |-> $past(fail_raw_r, 2) && $past(fail_s1_r))
		else $error("failure skipped the synchroniser");
	a_fail_stays: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_FAIL && !sleep_req && !scs_chg |=> state_r == ST_FAIL)
		else $error("left fail-safe without firmware");

	c_reach_ext: cover property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_HOLD ##1 state_r == ST_EXT);
	c_fail_seen: cover property (@(posedge aclk) disable iff (!aresetn) fail_det);
	c_sleep_abort: cover property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_COUNT && sleep_req);
	c_retry_after_fail: cover property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_FAIL && scs_chg);

endmodule

//--- bench/osc_model.sv
// Purpose: Behavioural crystal, internal and low-frequency oscillator sources.
// Assumes: One aclk domain; oscillator levels change just after a rising edge.
// Notes:   A stopped crystal freezes at its last level, as a dead one would.
`timescale 1ns/1ps
module osc_model (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Bench control
	input  wire logic ext_run,
	input  wire logic pll_on,
	// Oscillator levels
	output logic      ext_osc_in,
	output logic      int_osc_in,
	output logic      lf_osc_in,
	output logic      pll_ready_bit
);
	logic [2:0] phase_r;
	logic [1:0] int_div_r;

	// ==========================================================
	// Sources: external period 4, internal period 6, low-freq period 8
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_r       <= 3'h0;
			int_div_r     <= 2'h0;
			ext_osc_in    <= 1'b0;
			int_osc_in    <= 1'b0;
			lf_osc_in     <= 1'b0;
			pll_ready_bit <= 1'b0;
		end else begin
			phase_r       <= phase_r + 3'h1;
			ext_osc_in    <= ext_run ? phase_r[1] : ext_osc_in;
			lf_osc_in     <= phase_r[2];
			int_div_r     <= (int_div_r == 2'h2) ? 2'h0 : int_div_r + 2'h1;
			int_osc_in    <= (int_div_r == 2'h2) ? ~int_osc_in : int_osc_in;
			pll_ready_bit <= pll_on;
		end
	end
endmodule

//--- bench/two_speed_startup_fail_safe_monitor_tb_top.sv
// Purpose: Register-level tests of start-up sequencing and clock failure handling.
// Assumes: Counts shrunk to 8 timer edges and a divide of 8 to keep the run short.
// Notes:   STATUS is polled; the sequencer moves slower than one bus read.
`timescale 1ns/1ps
module two_speed_startup_fail_safe_monitor_tb_top;
	import clk_sup_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        ext_osc_in, int_osc_in, lf_osc_in, pll_ready_bit;
	logic        ext_run = 1'b1;
	logic        pll_on = 1'b0;
	logic [1:0]  clk_mux_sel;
	logic [3:0]  internal_freq_select;
	logic        startup_done_bit;
	logic        osc_fail_irq;
	int          n_mismatch = 0;
	int          checked = 0;
	logic [31:0] d;
	logic [1:0]  r;

	always #5 aclk = ~aclk;

	osc_model i_osc (.aclk(aclk), .aresetn(aresetn), .ext_run(ext_run), .pll_on(pll_on),
		.ext_osc_in(ext_osc_in), .int_osc_in(int_osc_in), .lf_osc_in(lf_osc_in),
		.pll_ready_bit(pll_ready_bit));

	clk_supervisor #(.OST_EDGES(8), .SAMPLE_DIV(8), .POWER_UP_TIMER_EDGES(2)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .ext_osc_in(ext_osc_in),
		.int_osc_in(int_osc_in), .lf_osc_in(lf_osc_in), .pll_ready_bit(pll_ready_bit),
		.clk_mux_sel(clk_mux_sel), .internal_freq_select(internal_freq_select),
		.startup_done_bit(startup_done_bit), .osc_fail_irq(osc_fail_irq));

	// ==========================================================
	// Compare, bus tasks and verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; leaves one idle edge after the response
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		awaddr  <= a;
		wdata   <= v;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er);
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rr = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] v;
		logic [1:0]  rr;
		rd(a, v, rr);
		chk(v & m, e);
	endtask

	// Bounded poll of STATUS until the masked value matches
	task automatic poll(input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rr;
		for (int i = 0; i < 60; i++) begin
			rd(STATUS_OFS, v, rr);
			if ((v & m) === e) break;
		end
		chk(v & m, e);
	endtask

	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(CFG_OFS, 32'h1A, 32'hFF);
		rchk(CTRL_OFS, 32'h1C, 32'hFF);
		chk(internal_freq_select, FREQ_SEL_RST);
		poll(32'hE7, 32'h60);
		poll(32'hFF, 32'hC5);
		chk(clk_mux_sel, SEL_EXT);
		chk(startup_done_bit, 1'b1);
		// Sleep, wake, then sleep again before the count completes
		wr(CMD_OFS, 32'h1, AXI_OKAY);
		wr(CMD_OFS, 32'h2, AXI_OKAY);
		poll(32'hE7, 32'h60);
		wr(CMD_OFS, 32'h1, AXI_OKAY);
		rchk(STATUS_OFS, 32'h20, 32'hE1);
		chk(startup_done_bit, 1'b0);
		// Every crystal mode with two-speed on, then HS with switchover off
		for (int k = 0; k < 4; k++) begin
			wr(CFG_OFS, (k < 3) ? 32'h18 | k : 32'h02, AXI_OKAY);
			wr(CMD_OFS, 32'h2, AXI_OKAY);
			poll(32'hE7, (k < 3) ? 32'h60 : 32'h62);
			poll(32'hFF, 32'hC5);
			wr(CMD_OFS, 32'h1, AXI_OKAY);
		end
		// Switch confirmation while asleep
		pll_on <= 1'b1;
		poll(32'h08, 32'h08);
		pll_on <= 1'b0;
		// Resistor-capacitor mode: no timer, monitor active at once
		wr(CTRL_OFS, 32'h38, AXI_OKAY);
		chk(internal_freq_select, 4'hE);
		wr(CFG_OFS, {29'h0, OSC_RC} | 32'h18, AXI_OKAY);
		wr(IRQ_OFS, 32'h2, AXI_OKAY);
		wr(CMD_OFS, 32'h2, AXI_OKAY);
		rchk(STATUS_OFS, 32'hC5, 32'hE7);
		ext_run <= 1'b0;
		poll(32'hF7, 32'hF0);
		rchk(IRQ_OFS, 32'h3, 32'hFF);
		chk(osc_fail_irq, 1'b1);
		chk(clk_mux_sel, SEL_INT);
		wr(IRQ_OFS, 32'h3, AXI_OKAY);
		rchk(IRQ_OFS, 32'h2, 32'hFF);
		// Switching back onto a still-dead clock fails and flags again
		wr(CTRL_OFS, 32'h3A, AXI_OKAY);
		wr(CTRL_OFS, 32'h38, AXI_OKAY);
		poll(32'hF7, 32'hF0);
		rchk(IRQ_OFS, 32'h3, 32'hFF);
		chk(osc_fail_irq, 1'b1);
		wr(IRQ_OFS, 32'h3, AXI_OKAY);
		// A restarted crystal alone does not end the fallback
		ext_run <= 1'b1;
		repeat (40) @(posedge aclk);
		rchk(STATUS_OFS, 32'hF0, 32'hF7);
		wr(CTRL_OFS, 32'h3A, AXI_OKAY);
		poll(32'hE7, 32'h40);
		wr(IRQ_OFS, 32'h3, AXI_OKAY);
		rchk(IRQ_OFS, 32'h2, 32'hFF);
		wr(CTRL_OFS, 32'h38, AXI_OKAY);
		poll(32'hFF, 32'hC5);
		chk(osc_fail_irq, 1'b0);
		// Unmapped and read-only places
		rd(8'h20, d, r);
		chk(r, AXI_SLVERR);
		chk(d, 32'h0);
		wr(8'h20, 32'hFF, AXI_SLVERR);
		wr(STATUS_OFS, 32'h0, AXI_SLVERR);
		rchk(STATUS_OFS, 32'hC5, 32'hFF);
		finish_test();
	end

	// Hang guard, far beyond the several hundred cycles the tests need
	initial begin
		#300000;
		n_mismatch++;
		finish_test();
	end
endmodule
